// ---- esm_pkg.sv ----
// Constants, types and decode helpers shared by the equalizer, strap and
// audio clock divider register bank.
// Assumes an 8-bit register address space and 8-bit register data.

package esm_pkg;

    // -------------------------------------------------------------------
    // Register offsets
    // -------------------------------------------------------------------
    localparam logic [7:0] ESM_OFS_ADAPT_CTRL  = 8'h35;
    localparam logic [7:0] ESM_OFS_STRAP_STAT  = 8'h37;
    localparam logic [7:0] ESM_OFS_DIV_CTRL    = 8'h3a;
    localparam logic [7:0] ESM_OFS_EQ_READBACK = 8'h3b;

    // -------------------------------------------------------------------
    // Reset values
    // -------------------------------------------------------------------
    localparam logic [7:0] ESM_RST_ADAPT_CTRL  = 8'h00;
    localparam logic [7:0] ESM_RST_DIV_CTRL    = 8'h00;
    localparam logic [2:0] ESM_RST_STRAP_CODE  = 3'h0;

    // -------------------------------------------------------------------
    // Field positions
    // -------------------------------------------------------------------
    localparam int ESM_ADAPT_RESTART_BIT = 6;
    localparam int ESM_FLOOR_OVR_BIT     = 5;
    localparam int ESM_FLOOR_SEL_BIT     = 4;
    localparam int ESM_STRAP1_DONE_BIT   = 7;
    localparam int ESM_STRAP1_LSB        = 4;
    localparam int ESM_STRAP0_DONE_BIT   = 3;
    localparam int ESM_STRAP0_LSB        = 0;
    localparam int ESM_MDIV_OVR_BIT      = 7;
    localparam int ESM_MDIV_LSB          = 4;
    localparam int ESM_MSEL_OVR_BIT      = 2;
    localparam int ESM_MSEL_LSB          = 0;
    localparam int ESM_STAGE_W           = 3;
    localparam int ESM_EQ_W              = 6;

    // Writable bits; everything else is reserved and reads as zero
    localparam logic [7:0] ESM_ADAPT_WMASK = 8'h70;
    localparam logic [7:0] ESM_DIV_WMASK   = 8'hf7;

    // -------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------
    localparam int ESM_CLK_PERIOD_NS   = 40;
    localparam int ESM_STRAP_SETTLE_NS = 1000;
    // Least time, so round up
    localparam int ESM_STRAP_SETTLE_CYC =
        (ESM_STRAP_SETTLE_NS + ESM_CLK_PERIOD_NS - 1) / ESM_CLK_PERIOD_NS;

    // -------------------------------------------------------------------
    // Strap meanings
    // -------------------------------------------------------------------
    localparam logic [1:0] ESM_OUT_DUAL      = 2'h0;
    localparam logic [1:0] ESM_OUT_DUAL_SWAP = 2'h1;
    localparam logic [1:0] ESM_OUT_SINGLE    = 2'h2;
    localparam logic [1:0] ESM_OUT_REPLICATE = 2'h3;

    typedef enum logic [2:0] {
        ESM_ST_SETTLE = 3'b001,
        ESM_ST_SAMPLE = 3'b010,
        ESM_ST_DONE   = 3'b100
    } esm_strap_e;

    // -------------------------------------------------------------------
    // Divider decodes
    // -------------------------------------------------------------------
    function automatic logic [5:0] esm_mdiv_ratio(input logic [2:0] code);
        logic [5:0] r;
        r = 6'h01;
        unique case (code)
            3'h0: r = 6'h20;
            3'h1: r = 6'h10;
            3'h2: r = 6'h08;
            3'h3: r = 6'h04;
            3'h4,
            3'h5: r = 6'h02;
            3'h6,
            3'h7: r = 6'h01;
        endcase
        return r;
    endfunction

    function automatic logic [3:0] esm_msel_ratio(input logic [1:0] code);
        logic [3:0] r;
        r = 4'h1;
        unique case (code)
            2'h0: r = 4'h1;
            2'h1: r = 4'h2;
            2'h2: r = 4'h4;
            2'h3: r = 4'h8;
        endcase
        return r;
    endfunction

endpackage

// ---- esm_strap_latch.sv ----
// Latches one three-level-coded configuration strap after a settle delay
// and flags completion.
// Assumes the strap level is static and synchronous to clk.

`timescale 1ns/1ps

module esm_strap_latch
    import esm_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // Strap level
    input  wire logic [2:0] strap_level,
    // Latched result
    output logic      [2:0] code,
    output logic            done
);
    import esm_pkg::*;

    localparam logic [7:0] SETTLE_LAST = 8'(ESM_STRAP_SETTLE_CYC - 1);

    typedef struct packed {
        esm_strap_e st;
        logic [7:0] cnt;
        logic [2:0] code;
        logic       done;
    } esm_latch_s;

    esm_latch_s s_r;
    esm_latch_s s_nxt;

    always_comb begin
        s_nxt = s_r;
        unique case (s_r.st)
            ESM_ST_SETTLE: begin
                if (s_r.cnt == SETTLE_LAST) begin
                    s_nxt.st = ESM_ST_SAMPLE;
                end else begin
                    s_nxt.cnt = s_r.cnt + 8'h01;
                end
            end
            ESM_ST_SAMPLE: begin
                // Code and flag move together, so done never shows stale
                s_nxt.code = strap_level;
                s_nxt.done = 1'b1;
                s_nxt.st   = ESM_ST_DONE;
            end
            ESM_ST_DONE: begin
                s_nxt = s_r;
            end
            default: begin
                s_nxt.st = ESM_ST_SETTLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_r.st   <= ESM_ST_SETTLE;
            s_r.cnt  <= 8'h00;
            s_r.code <= ESM_RST_STRAP_CODE;
            s_r.done <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign code = s_r.code;
    assign done = s_r.done;

endmodule

// ---- esm_regs.sv ----
// Register bank for equalizer adaptation control, strap decode status,
// audio master clock divider override and equalizer setting readback.
// Assumes a simple single-cycle register port in front of it and that the
// port select bit, bypass settings and floor values come from elsewhere.
//
// Function
// - While restart is high, adaptation restarts from its start value on both ports.
// - The restart bit is plain read/write and never clears itself.
// - Floor select takes effect only while the floor override enable is one.
// - With the floor active, adaptation starts from the floor value, else from zero.
// - Writes to the adaptation control register go to port 1 when port 1 is selected.
// - Reads of the equalizer readback return port 1 when port 1 is selected.
// - The strap 1 done flag is zero until its decode is latched, then one.
// - Strap 1 code bits 6-4 give 5 or 20 Mbps by bit 5 and twisted pair or coax by bit 4.
// - The strap 0 done flag is zero until its decode is latched, then one.
// - Strap 0 code bits 2-0 give dual, dual swapped, single or replicate by the low two bits.
// - The master clock divider uses the automatic choice unless its override is one.
// - Divider code 0..3 divides by 32,16,8,4; codes 4,5 by 2; codes 6,7 by 1.
// - The predivider uses the sequencer ratio unless its override is one.
// - Predivider code 0..3 divides by 1,2,4,8.
// - Readback shows stage two and one when bypassed, else the adaptive value.
// - Port 1 select routes port register accesses to port 1; shared registers always write.

`timescale 1ns/1ps

module esm_regs
    import esm_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // Register port
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    output logic            reg_rd_valid,
    // Port routing
    input  wire logic       second_port_select,
    // Configuration straps
    input  wire logic [2:0] strap0_level,
    input  wire logic [2:0] strap1_level,
    // Port 0 equalizer side
    input  wire logic       adaptation_bypass_p0,
    input  wire logic [2:0] equalizer_stage_one_p0,
    input  wire logic [2:0] equalizer_stage_two_p0,
    input  wire logic [5:0] adaptive_equalizer_value_p0,
    input  wire logic [5:0] floor_value_p0,
    // Port 1 equalizer side
    input  wire logic       adaptation_bypass_p1,
    input  wire logic [2:0] equalizer_stage_one_p1,
    input  wire logic [2:0] equalizer_stage_two_p1,
    input  wire logic [5:0] adaptive_equalizer_value_p1,
    input  wire logic [5:0] floor_value_p1,
    // Adaptation controls to the equalizers
    output logic            adapt_restart_p0,
    output logic            adapt_restart_p1,
    output logic            floor_active_p0,
    output logic            floor_active_p1,
    output logic      [5:0] adapt_start_value_p0,
    output logic      [5:0] adapt_start_value_p1,
    // Decoded straps
    output logic            strap0_decode_complete,
    output logic      [1:0] strap0_output_mode,
    output logic            strap1_decode_complete,
    output logic            strap1_rate_20m,
    output logic            strap1_coax,
    // Clock divider selection
    input  wire logic [2:0] mdiv_auto,
    input  wire logic [1:0] msel_auto,
    output logic      [2:0] mdiv_active,
    output logic      [1:0] msel_active,
    output logic            ref_div_en,
    output logic            mclk_en
);
    import esm_pkg::*;

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    // Bypass shows the manual stage values, stage two in the high half
    function automatic logic [5:0] eq_view(
        input logic       bypass,
        input logic [2:0] stage_two,
        input logic [2:0] stage_one,
        input logic [5:0] adaptive
    );
        logic [5:0] v;
        v = adaptive;
        if (bypass) begin
            v = {stage_two, stage_one};
        end
        return v;
    endfunction

    function automatic logic floor_on(input logic [7:0] ctrl);
        return ctrl[ESM_FLOOR_OVR_BIT] & ctrl[ESM_FLOOR_SEL_BIT];
    endfunction

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [1:0][7:0] adapt;
        logic [7:0]      div;
        logic [7:0]      rdata;
        logic            rd_valid;
        logic [1:0]      restart;
        logic [1:0]      floor_act;
        logic [1:0][5:0] start_val;
        logic [2:0]      mdiv_act;
        logic [1:0]      msel_act;
        logic [3:0]      pre_cnt;
        logic            pre_en;
        logic [5:0]      mclk_cnt;
        logic            mclk_en;
    } esm_regs_s;

    esm_regs_s s_r;
    esm_regs_s s_nxt;

    logic [2:0] strap0_code;
    logic [2:0] strap1_code;
    logic       strap0_done;
    logic       strap1_done;

    // ---------------------------------------------------------------
    // Strap capture
    // ---------------------------------------------------------------
    esm_strap_latch u_strap0 (
        .clk         (clk),
        .rstn        (rstn),
        .strap_level (strap0_level),
        .code        (strap0_code),
        .done        (strap0_done)
    );

    esm_strap_latch u_strap1 (
        .clk         (clk),
        .rstn        (rstn),
        .strap_level (strap1_level),
        .code        (strap1_code),
        .done        (strap1_done)
    );

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    logic       port;
    logic [7:0] strap_word;
    logic [5:0] view;
    logic [3:0] pre_ratio;
    logic [5:0] mclk_ratio;

    always_comb begin
        s_nxt      = s_r;
        port       = second_port_select;
        strap_word = 8'h00;
        view       = 6'h00;
        pre_ratio  = 4'h1;
        mclk_ratio = 6'h01;

        // Register writes
        if (reg_wr) begin
            if (reg_addr == ESM_OFS_ADAPT_CTRL) begin
                // Only the selected port copy changes
                // Reserved bits are dropped here
                // Restart holds whatever software wrote
                s_nxt.adapt[port] = reg_wdata & ESM_ADAPT_WMASK;
            end
            if (reg_addr == ESM_OFS_DIV_CTRL) begin
                // Shared register, written whatever port is selected
                s_nxt.div = reg_wdata & ESM_DIV_WMASK;
            end
        end

        // Adaptation controls to both equalizers
        // Either copy of the bit restarts both ports
        s_nxt.restart = {2{s_r.adapt[0][ESM_ADAPT_RESTART_BIT]
                         | s_r.adapt[1][ESM_ADAPT_RESTART_BIT]}};
        s_nxt.floor_act[0] = floor_on(s_r.adapt[0]);
        s_nxt.floor_act[1] = floor_on(s_r.adapt[1]);
        s_nxt.start_val[0] = floor_on(s_r.adapt[0]) ? floor_value_p0
                                                     : 6'h00;
        s_nxt.start_val[1] = floor_on(s_r.adapt[1]) ? floor_value_p1
                                                     : 6'h00;

        // Divider selection
        s_nxt.mdiv_act = s_r.div[ESM_MDIV_OVR_BIT]
                       ? s_r.div[ESM_MDIV_LSB +: 3] : mdiv_auto;
        s_nxt.msel_act = s_r.div[ESM_MSEL_OVR_BIT]
                       ? s_r.div[ESM_MSEL_LSB +: 2] : msel_auto;

        // Enable pulses; compare with >= so a ratio cut mid-count
        // cannot leave the counter stranded above its new limit
        pre_ratio  = esm_msel_ratio(s_r.msel_act);
        mclk_ratio = esm_mdiv_ratio(s_r.mdiv_act);
        s_nxt.pre_en  = 1'b0;
        s_nxt.mclk_en = 1'b0;
        if (s_r.pre_cnt >= pre_ratio - 4'h1) begin
            s_nxt.pre_cnt = 4'h0;
            s_nxt.pre_en  = 1'b1;
        end else begin
            s_nxt.pre_cnt = s_r.pre_cnt + 4'h1;
        end
        if (s_r.pre_en) begin
            if (s_r.mclk_cnt >= mclk_ratio - 6'h01) begin
                s_nxt.mclk_cnt = 6'h00;
                s_nxt.mclk_en  = 1'b1;
            end else begin
                s_nxt.mclk_cnt = s_r.mclk_cnt + 6'h01;
            end
        end

        // Status word: flags stay low until each code is latched
        strap_word[ESM_STRAP1_DONE_BIT]       = strap1_done;
        strap_word[ESM_STRAP1_LSB +: 3]       = strap1_code;
        strap_word[ESM_STRAP0_DONE_BIT]       = strap0_done;
        strap_word[ESM_STRAP0_LSB +: 3]       = strap0_code;

        // Equalizer readback for the selected port
        if (port) begin
            view = eq_view(adaptation_bypass_p1, equalizer_stage_two_p1,
                           equalizer_stage_one_p1,
                           adaptive_equalizer_value_p1);
        end else begin
            view = eq_view(adaptation_bypass_p0, equalizer_stage_two_p0,
                           equalizer_stage_one_p0,
                           adaptive_equalizer_value_p0);
        end

        // Register reads; unmapped addresses return zero
        s_nxt.rd_valid = reg_rd;
        if (reg_rd) begin
            unique case (reg_addr)
                ESM_OFS_ADAPT_CTRL:  s_nxt.rdata = s_r.adapt[port];
                ESM_OFS_STRAP_STAT:  s_nxt.rdata = strap_word;
                ESM_OFS_DIV_CTRL:    s_nxt.rdata = s_r.div;
                ESM_OFS_EQ_READBACK: s_nxt.rdata = {2'b00, view};
                default:             s_nxt.rdata = 8'h00;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_r.adapt     <= {2{ESM_RST_ADAPT_CTRL}};
            s_r.div       <= ESM_RST_DIV_CTRL;
            s_r.rdata     <= 8'h00;
            s_r.rd_valid  <= 1'b0;
            s_r.restart   <= 2'b00;
            s_r.floor_act <= 2'b00;
            s_r.start_val <= {2{6'h00}};
            s_r.mdiv_act  <= 3'h0;
            s_r.msel_act  <= 2'h0;
            s_r.pre_cnt   <= 4'h0;
            s_r.pre_en    <= 1'b0;
            s_r.mclk_cnt  <= 6'h00;
            s_r.mclk_en   <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign reg_rdata            = s_r.rdata;
    assign reg_rd_valid         = s_r.rd_valid;
    assign adapt_restart_p0     = s_r.restart[0];
    assign adapt_restart_p1     = s_r.restart[1];
    assign floor_active_p0      = s_r.floor_act[0];
    assign floor_active_p1      = s_r.floor_act[1];
    assign adapt_start_value_p0 = s_r.start_val[0];
    assign adapt_start_value_p1 = s_r.start_val[1];
    assign mdiv_active          = s_r.mdiv_act;
    assign msel_active          = s_r.msel_act;
    assign ref_div_en           = s_r.pre_en;
    assign mclk_en              = s_r.mclk_en;

    // Decoded straps; the top code bit does not change the meaning
    assign strap0_decode_complete = strap0_done;
    assign strap1_decode_complete = strap1_done;
    assign strap0_output_mode     = strap0_code[1:0];
    assign strap1_rate_20m        = strap1_code[1];
    assign strap1_coax            = strap1_code[0];

endmodule

// ---- esm_regs_props.sv ----
// Concurrent checks for the equalizer, strap and divider register bank.
// Assumes it is bound onto esm_regs and sees that module's ports only.

`timescale 1ns/1ps

module esm_regs_props (
    // Clock and reset
    input wire logic       clk,
    input wire logic       rstn,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       reg_rd_valid,
    input wire logic       second_port_select,
    // Port 0 equalizer side
    input wire logic       adaptation_bypass_p0,
    input wire logic [2:0] equalizer_stage_one_p0,
    input wire logic [2:0] equalizer_stage_two_p0,
    // Controls and status out
    input wire logic       adapt_restart_p0,
    input wire logic       adapt_restart_p1,
    input wire logic       floor_active_p0,
    input wire logic [5:0] adapt_start_value_p0,
    input wire logic       strap1_decode_complete,
    input wire logic       strap1_rate_20m,
    input wire logic [2:0] mdiv_active
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // -------------------------------------------------------------------
    // Write steps
    // -------------------------------------------------------------------
    // The second step keeps a later write from masking the first one
    sequence wr_restart_s;
        reg_wr && reg_addr == 8'h35 && reg_wdata[6]
        ##1 !(reg_wr && reg_addr == 8'h35);
    endsequence
    sequence wr_nofloor_s;
        reg_wr && reg_addr == 8'h35 && !reg_wdata[5] && !second_port_select
        ##1 !(reg_wr && reg_addr == 8'h35);
    endsequence
    sequence wr_mdiv_s;
        reg_wr && reg_addr == 8'h3a && reg_wdata[7]
        ##1 !(reg_wr && reg_addr == 8'h3a);
    endsequence

    // -------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------
    rd_answer_a: assert property (reg_rd |=> reg_rd_valid)
        else $error("read not answered one cycle later");
    rd_quiet_a: assert property (!reg_rd |=> !reg_rd_valid)
        else $error("read valid without a read");
    rdata_hold_a: assert property (!reg_rd_valid |-> $stable(reg_rdata))
        else $error("read data moved without a read");
    restart_set_a: assert property (wr_restart_s |=>
        adapt_restart_p0 && adapt_restart_p1)
        else $error("restart write did not reach both ports");
    restart_pair_a: assert property (adapt_restart_p0 == adapt_restart_p1)
        else $error("restart differs between ports");
    restart_hold_a: assert property (
        !(reg_wr && reg_addr == 8'h35) [*2] |=> $stable(adapt_restart_p0))
        else $error("restart changed without a write");
    floor_gate_a: assert property (wr_nofloor_s |=> !floor_active_p0)
        else $error("floor active without override");
    floor_zero_a: assert property (
        !floor_active_p0 && !$past(floor_active_p0)
        |-> adapt_start_value_p0 == 6'h00)
        else $error("start value not zero without floor");
    mdiv_ovr_a: assert property (
        wr_mdiv_s |=> mdiv_active == $past(reg_wdata[6:4], 2))
        else $error("divider override code not applied");
    eq_bypass_a: assert property (
        reg_rd && reg_addr == 8'h3b && !second_port_select
        && adaptation_bypass_p0 |=> reg_rdata == {2'b00,
        $past(equalizer_stage_two_p0), $past(equalizer_stage_one_p0)})
        else $error("bypassed readback wrong");
    strap_hold_a: assert property (strap1_decode_complete |=>
        strap1_decode_complete && $stable(strap1_rate_20m))
        else $error("strap result changed after latch");
endmodule

bind esm_regs esm_regs_props chk_u (.*);

// ---- tb_top.sv ----
// Self-checking bench for the register bank: straps, adaptation controls,
// divider overrides and ratios, readback and reserved places.
// Assumes esm_pkg and the bound checker are compiled before it.

`timescale 1ns/1ps

module tb_top;
    import esm_pkg::*;

    logic       clk, rstn, reg_wr, reg_rd, reg_rd_valid, second_port_select;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, v, e, m_e;
    logic [2:0] strap0_level, strap1_level, mdiv_auto, mdiv_active;
    logic       adaptation_bypass_p0, adaptation_bypass_p1;
    logic [2:0] equalizer_stage_one_p0, equalizer_stage_two_p0;
    logic [2:0] equalizer_stage_one_p1, equalizer_stage_two_p1;
    logic [5:0] adaptive_equalizer_value_p0, adaptive_equalizer_value_p1;
    logic [5:0] floor_value_p0, floor_value_p1;
    logic [5:0] adapt_start_value_p0, adapt_start_value_p1;
    logic       adapt_restart_p0, adapt_restart_p1;
    logic       floor_active_p0, floor_active_p1, ref_div_en, mclk_en;
    logic       strap0_decode_complete, strap1_decode_complete;
    logic       strap1_rate_20m, strap1_coax;
    logic [1:0] strap0_output_mode, msel_auto, msel_active;
    int         failures, check_count, seed, per;
    logic [7:0] exp_q[$];
    int         dv[8] = '{32, 16, 8, 4, 2, 2, 1, 1};

    // Every port connects to the bench signal that carries its name
    esm_regs dut_u (.*);

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // -------------------------------------------------------------------
    // Compare, finish and bus tasks
    // -------------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        $display("checks=%0d mismatches=%0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Each access ends with an idle cycle so strobes never flip twice
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        tick(1);
        reg_wr = 1'b0;
        tick(1);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        exp_q.push_back(x);
        {reg_rd, reg_addr} = {1'b1, a};
        tick(1);
        reg_rd = 1'b0;
        tick(1);
    endtask

    // Read results are matched in issue order
    always @(negedge clk) begin
        if (reg_rd_valid === 1'b1) begin
            m_e = (exp_q.size() > 0) ? exp_q.pop_front() : ~reg_rdata;
            chk(reg_rdata, m_e);
        end
    end

    task automatic do_reset(input logic [2:0] s0, input logic [2:0] s1);
        int n;
        {rstn, strap0_level, strap1_level} = {1'b0, s0, s1};
        tick(16);
        rstn = 1'b1;
        rd(8'h37, 8'h00);
        rd(8'h35, 8'h00);
        rd(8'h3a, 8'h00);
        n = 0;
        while (!(strap0_decode_complete && strap1_decode_complete) && n < 99) begin
            tick(1);
            n++;
        end
        if (n == 99) begin
            failures++;
            test_done();
        end
        chk(8'(strap0_output_mode), 8'(s0[1:0]));
        chk(8'({strap1_rate_20m, strap1_coax}), 8'(s1[1:0]));
        rd(8'h37, {1'b1, s1, 1'b1, s0});
    endtask

    // Cycles between two divided clock enables, after settling
    task automatic period(output int p);
        int n;
        tick(80);
        n = 0;
        while (mclk_en !== 1'b1 && n < 99) begin
            tick(1);
            n++;
        end
        p = 0;
        do begin
            tick(1);
            p++;
        end while (mclk_en !== 1'b1 && p < 99);
        if (n == 99 || p == 99) begin
            failures++;
            test_done();
        end
    endtask

    // -------------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------------
    initial begin
        {failures, check_count, seed} = {32'h0, 32'h0, 32'hf3b1};
        {reg_addr, reg_wr, reg_wdata, reg_rd, second_port_select} = '0;
        {adaptation_bypass_p0, adaptation_bypass_p1} = '0;
        {equalizer_stage_one_p0, equalizer_stage_two_p0} = '0;
        {equalizer_stage_one_p1, equalizer_stage_two_p1} = '0;
        {adaptive_equalizer_value_p0, adaptive_equalizer_value_p1} = '0;
        {floor_value_p0, floor_value_p1, mdiv_auto, msel_auto} = 17'h0aa5d;
        for (int i = 0; i < 8; i++)
            do_reset(3'(i), ~3'(i));
        wr(8'h35, 8'hff);
        tick(10);
        chk(8'({adapt_restart_p0, adapt_restart_p1}), 8'h03);
        chk(8'(floor_active_p0), 8'h01);
        chk(8'(adapt_start_value_p0), 8'(floor_value_p0));
        rd(8'h35, 8'h70);
        second_port_select = 1'b1;
        wr(8'h35, 8'h20);
        rd(8'h35, 8'h20);
        chk(8'({floor_active_p1, floor_active_p0}), 8'h01);
        chk(8'(adapt_start_value_p1), 8'h00);
        wr(8'h35, 8'h30);
        tick(1);
        chk(8'(adapt_start_value_p1), 8'(floor_value_p1));
        second_port_select = 1'b0;
        wr(8'h35, 8'h10);
        tick(1);
        chk(8'({adapt_restart_p0, floor_active_p0}), 8'h00);
        chk(8'(adapt_start_value_p0), 8'h00);
        for (int i = 0; i < 12; i++) begin
            v = 8'($random(seed));
            {mdiv_auto, msel_auto} = 5'($random(seed));
            wr(8'h3a, v);
            rd(8'h3a, v & 8'hf7);
            chk(8'(mdiv_active), 8'(v[7] ? v[6:4] : mdiv_auto));
            chk(8'(msel_active), 8'(v[2] ? v[1:0] : msel_auto));
        end
        for (int k = 0; k < 12; k++) begin
            if (k < 8)
                wr(8'h3a, {1'b1, 3'(k), 4'h4});
            else
                wr(8'h3a, {4'hf, 2'h1, 2'(k - 8)});
            period(per);
            if (k < 8) chk(8'(ref_div_en), 8'h01);
            chk(8'(per), 8'(k < 8 ? dv[k] : 1 << (k - 8)));
        end
        for (int i = 0; i < 16; i++) begin
            {adaptation_bypass_p0, equalizer_stage_one_p0, equalizer_stage_two_p0,
             adaptation_bypass_p1, equalizer_stage_one_p1, equalizer_stage_two_p1,
             second_port_select} = 15'($random(seed));
            {adaptive_equalizer_value_p0,
             adaptive_equalizer_value_p1} = 12'($random(seed));
            if (second_port_select)
                e = adaptation_bypass_p1 ? {2'b00, equalizer_stage_two_p1,
                    equalizer_stage_one_p1} : 8'(adaptive_equalizer_value_p1);
            else
                e = adaptation_bypass_p0 ? {2'b00, equalizer_stage_two_p0,
                    equalizer_stage_one_p0} : 8'(adaptive_equalizer_value_p0);
            rd(8'h3b, e);
        end
        second_port_select = 1'b0;
        do_reset(3'h2, 3'h5);
        wr(8'h36, 8'hff);
        rd(8'h36, 8'h00);
        wr(8'h37, 8'h00);
        rd(8'h37, 8'hda);
        wr(8'h35, 8'h8f);
        rd(8'h35, 8'h00);
        tick(4);
        if (exp_q.size() != 0)
            failures++;
        test_done();
    end
endmodule
